/* File: rtl/rss_filt_if.sv */
// Interface carrying one glitch filter's raw input and filtered level.
// Assumes the producer and the consumer share REF_CLK.
interface rss_filt_if;
  logic raw;
  logic qual;
  modport src (output raw, input qual);
  modport flt (input raw, output qual);
endinterface

/* File: rtl/rss_glitch_filter.sv */
// Width qualifier: the output goes high once the input has been high for LEN cycles.
// Assumes the input is already synchronised to the clock.
module rss_glitch_filter
  import rss_pkg::*;
#(
  parameter int unsigned LEN = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  rss_filt_if.flt fi
);
  logic [FILT_W-1:0] cnt_q;
  // Count consecutive active cycles, drop at once on a gap
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (!fi.raw) begin
      cnt_q <= '0;
    end else if (cnt_q < FILT_W'(LEN)) begin
      cnt_q <= cnt_q + FILT_W'(1);
    end
  end
  assign fi.qual = fi.raw && (cnt_q >= FILT_W'(LEN));
endmodule

/* File: rtl/rss_pkg.sv */
// Package for the reset source sequencer: register map, field positions, timing.
// Assumes a single 100 MHz reference clock and an 8-bit register port.
package rss_pkg;
  // Clock
  localparam int unsigned CLK_MHZ = 100;
  // Minimum external reset pulse, ns, and its cycle count (rounded up)
  localparam int unsigned PIN_MIN_NS = 2500;
  localparam int unsigned PIN_MIN_CYC = (PIN_MIN_NS * CLK_MHZ + 999) / 1000;
  // Minimum brown-out dip width, ns, and its cycle count (at least one)
  localparam int unsigned BOD_MIN_NS = 2;
  localparam int unsigned BOD_MIN_RAW = (BOD_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned BOD_MIN_CYC = (BOD_MIN_RAW < 1) ? 1 : BOD_MIN_RAW;
  localparam int unsigned FILT_W = 9;
  // Register addresses
  localparam logic [3:0] ADDR_CAUSE = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h1;
  localparam logic [3:0] ADDR_MASK = 4'h2;
  // Reset-cause field positions
  localparam int unsigned BIT_POR = 0;
  localparam int unsigned BIT_PIN = 1;
  localparam int unsigned BIT_BOD = 2;
  localparam int unsigned BIT_WDT = 3;
  localparam logic [7:0] CAUSE_MASK = 8'h0f;
  localparam logic [7:0] STAT_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  // Brown-out level fuse codes
  localparam logic [2:0] BODL_OFF = 3'h7;
  localparam logic [2:0] BODL_LVL_A = 3'h6;
  localparam logic [2:0] BODL_2V7 = 3'h5;
  localparam logic [2:0] BODL_4V3 = 3'h4;
  // Start-up time-out selection: index from start-up and clock-select fuses
  localparam int unsigned TOUT_W = 20;
  typedef enum logic [1:0] {RSS_ST_HOLD, RSS_ST_DELAY, RSS_ST_RUN} rss_state_t;
endpackage

/* File: rtl/rss_top.sv */
// Reset source sequencer: combines four reset causes, stretches internal reset,
// records causes. Assumes analog detectors arrive as levels from outside the clock.
// Function
// - Hold I/O registers in reset; release to the reset vector afterwards.
// - Force ports to initial state immediately, without a clock; only pin and supply bypass the clock here.
// - Stretch internal reset by fuse-selected delay after all sources end.
// - Four causes: power-on, pin, watchdog, brown-out; any asserts reset.
// - Power-on reset follows low supply with no delay; release starts delay.
// - Pin low beyond minimum width resets; shorter pulses may be ignored.
// - Pin release starts delay; processor runs after the time-out.
// - Watchdog resets only when enabled with its interrupt option off.
// - Watchdog makes a one-cycle pulse; its fall starts the delay.
// - Enabled brown-out asserts at once; recovery starts the delay.
// - Brown-out ignores dips shorter than the minimum width.
// - Level fuse: all ones off, two known levels, one more, four reserved.
// - Watchdog flag bit 3: set by watchdog, cleared by power-on or zero write.
// - Brown-out flag bit 2: set by brown-out, cleared by power-on or zero write.
// - Pin flag bit 1: set by pin reset, cleared by power-on or zero write.
// - Power-on flag bit 0: set by power-on, cleared only by zero write.
//
// The address-and-strobe port and the address map were decided locally.
module rss_top
  import rss_pkg::*;
#(
  parameter logic [TOUT_W-1:0] TOUT_CYC0 = 20'h00400,
  parameter logic [TOUT_W-1:0] TOUT_CYC1 = 20'h01000,
  parameter logic [TOUT_W-1:0] TOUT_CYC2 = 20'h04000,
  parameter logic [TOUT_W-1:0] TOUT_CYC3 = 20'h10000
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // Reset sources
  input wire logic SUPPLY_LOW,
  input wire logic RESET_PIN_N,
  input wire logic WDT_EXPIRE,
  input wire logic WDT_ENABLE,
  input wire logic WDT_INT_ENABLE,
  input wire logic BOD_BELOW,
  // Fuses
  input wire logic [2:0] BROWNOUT_LEVEL_FUSES,
  input wire logic [1:0] STARTUP_TIME_FUSES,
  input wire logic [3:0] CLOCK_SELECT_FUSES,
  // Reset outputs
  output logic PORT_RESET,
  output logic CORE_RESET,
  output logic FETCH_VECTOR,
  output logic WDT_RESET_PULSE,
  output logic [1:0] BOD_TRIP_SEL,
  // Register port
  input wire logic [3:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  output logic IRQ
);
  logic por_s1_q, por_s2_q, pin_s1_q, pin_s2_q, bod_s1_q, bod_s2_q;
  logic por_act, pin_raw, pin_act, bod_en, bod_act, wdt_act, wdt_pulse_q, wdt_pulse_d;
  logic any_src, pin_fall_q;
  logic [TOUT_W-1:0] cnt_q, cnt_d, tout_sel;
  rss_state_t state_q, state_d;
  logic [7:0] cause_q, stat_q, mask_q, events;
  rss_filt_if pin_if ();
  rss_filt_if bod_if ();

  // Two-flop synchronisers for the asynchronous detector levels
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      por_s1_q <= 1'b1;
      por_s2_q <= 1'b1;
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      bod_s1_q <= 1'b0;
      bod_s2_q <= 1'b0;
    end else begin
      por_s1_q <= SUPPLY_LOW;
      por_s2_q <= por_s1_q;
      pin_s1_q <= !RESET_PIN_N;
      pin_s2_q <= pin_s1_q;
      bod_s1_q <= BOD_BELOW;
      bod_s2_q <= bod_s1_q;
    end
  end

  // Level fuse decode; reserved codes treated as disabled
  always_comb begin
    bod_en = 1'b0;
    BOD_TRIP_SEL = 2'h0;
    case (BROWNOUT_LEVEL_FUSES)
      BODL_LVL_A: begin
        bod_en = 1'b1;
        BOD_TRIP_SEL = 2'h1;
      end
      BODL_2V7: begin
        bod_en = 1'b1;
        BOD_TRIP_SEL = 2'h2;
      end
      BODL_4V3: begin
        bod_en = 1'b1;
        BOD_TRIP_SEL = 2'h3;
      end
      default: bod_en = 1'b0;
    endcase
  end

  // Width qualifiers reject short pin pulses and short supply dips
  assign pin_if.raw = pin_s2_q;
  assign bod_if.raw = bod_s2_q && bod_en;
  rss_glitch_filter #(.LEN(PIN_MIN_CYC)) u_pin_filt (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .fi(pin_if.flt)
  );
  rss_glitch_filter #(.LEN(BOD_MIN_CYC)) u_bod_filt (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .fi(bod_if.flt)
  );
  assign pin_act = pin_if.qual;
  assign bod_act = bod_if.qual;
  assign por_act = por_s2_q;

  // Watchdog reset only in pure system-reset mode
  assign wdt_act = WDT_EXPIRE && WDT_ENABLE && !WDT_INT_ENABLE;
  assign wdt_pulse_d = wdt_act && !wdt_pulse_q;
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      wdt_pulse_q <= 1'b0;
    end else begin
      wdt_pulse_q <= wdt_pulse_d;
    end
  end
  assign WDT_RESET_PULSE = wdt_pulse_q;

  // Any active source holds reset
  assign any_src = por_act || pin_act || bod_act || wdt_pulse_q;
  // Port reset bypasses the clock for pin and supply; raw levels are deliberate here
  assign PORT_RESET = SUPPLY_LOW || !RESET_PIN_N || any_src || (state_q != RSS_ST_RUN);

  // Time-out chosen from start-up and clock-select fuses
  always_comb begin
    case (STARTUP_TIME_FUSES ^ CLOCK_SELECT_FUSES[1:0])
      2'h0: tout_sel = TOUT_CYC0;
      2'h1: tout_sel = TOUT_CYC1;
      2'h2: tout_sel = TOUT_CYC2;
      default: tout_sel = TOUT_CYC3;
    endcase
  end

  // Sequencer: hold while sources active, then count the time-out
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      RSS_ST_HOLD: begin
        cnt_d = '0;
        if (!any_src) begin
          state_d = RSS_ST_DELAY;
        end
      end
      RSS_ST_DELAY: begin
        if (any_src) begin
          state_d = RSS_ST_HOLD;
          cnt_d = '0;
        end else if (cnt_q >= tout_sel - TOUT_W'(1)) begin
          state_d = RSS_ST_RUN;
        end else begin
          cnt_d = cnt_q + TOUT_W'(1);
        end
      end
      RSS_ST_RUN: begin
        if (any_src) begin
          state_d = RSS_ST_HOLD;
        end
      end
      default: state_d = RSS_ST_HOLD;
    endcase
  end
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      state_q <= RSS_ST_HOLD;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end
  assign CORE_RESET = (state_q != RSS_ST_RUN);
  // One-cycle pulse starting fetch at the reset vector
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      pin_fall_q <= 1'b0;
    end else begin
      pin_fall_q <= (state_q == RSS_ST_DELAY) && (state_d == RSS_ST_RUN);
    end
  end
  assign FETCH_VECTOR = pin_fall_q;

  // Cause events; power-on wins and clears the other flags
  assign events = {4'h0, wdt_pulse_q, bod_act, pin_act, por_act};
  function automatic logic [7:0] w0c(input logic [7:0] cur, input logic [7:0] wd);
    w0c = cur & wd; // Zero clears, one keeps
  endfunction
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      cause_q <= STAT_RESET;
    end else if (por_act) begin
      cause_q <= 8'h01 << BIT_POR;
    end else begin
      // Set wins over a software clear in the same cycle
      cause_q <= ((REG_WR && REG_ADDR == ADDR_CAUSE) ? w0c(cause_q, REG_WDATA) : cause_q)
                 | (events & CAUSE_MASK);
    end
  end

  // Interrupt status: sticky, write one to clear, set wins
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      stat_q <= STAT_RESET;
    end else begin
      stat_q <= ((REG_WR && REG_ADDR == ADDR_STAT) ? (stat_q & ~REG_WDATA) : stat_q)
                | (events & CAUSE_MASK);
    end
  end
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      mask_q <= MASK_RESET;
    end else if (REG_WR && REG_ADDR == ADDR_MASK) begin
      mask_q <= REG_WDATA & CAUSE_MASK;
    end
  end
  assign IRQ = |(stat_q & mask_q);

  // Read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      case (REG_ADDR)
        ADDR_CAUSE: REG_RDATA <= cause_q & CAUSE_MASK;
        ADDR_STAT: REG_RDATA <= stat_q;
        ADDR_MASK: REG_RDATA <= mask_q;
        default: REG_RDATA <= 8'h00;
      endcase
    end else begin
      REG_RDATA <= 8'h00;
    end
  end

  // Checks
  property p_wdt_one(c);
    @(posedge REF_CLK) disable iff (!RST_N) c |=> !c;
  endproperty
  a_wdt_one: assert property (p_wdt_one(wdt_pulse_q)) else $error("wdt pulse too long");
  property p_wdt_gate;
    @(posedge REF_CLK) disable iff (!RST_N) wdt_pulse_q |-> $past(WDT_ENABLE && !WDT_INT_ENABLE);
  endproperty
  a_wdt_gate: assert property (p_wdt_gate) else $error("wdt reset while gated");
  property p_hold;
    @(posedge REF_CLK) disable iff (!RST_N) any_src |=> CORE_RESET;
  endproperty
  a_hold: assert property (p_hold) else $error("core ran with source active");
  property p_delay;
    @(posedge REF_CLK) disable iff (!RST_N) $rose(state_q == RSS_ST_DELAY) |-> CORE_RESET[*2];
  endproperty
  a_delay: assert property (p_delay) else $error("no stretch");
  property p_por_flag;
    @(posedge REF_CLK) disable iff (!RST_N) por_act |=> cause_q[BIT_POR] && !cause_q[BIT_WDT];
  endproperty
  a_por_flag: assert property (p_por_flag) else $error("power-on flag wrong");
  property p_bod_flag;
    @(posedge REF_CLK) disable iff (!RST_N) bod_act && !por_act |=> cause_q[BIT_BOD];
  endproperty
  a_bod_flag: assert property (p_bod_flag) else $error("brown-out flag not set");
  property p_pin_flag;
    @(posedge REF_CLK) disable iff (!RST_N) pin_act && !por_act |=> cause_q[BIT_PIN];
  endproperty
  a_pin_flag: assert property (p_pin_flag) else $error("pin flag not set");
  property p_upper;
    @(posedge REF_CLK) disable iff (!RST_N) REG_RD |=> REG_RDATA[7:4] == 4'h0;
  endproperty
  a_upper: assert property (p_upper) else $error("upper bits nonzero");
  property p_keep_one;
    @(posedge REF_CLK) disable iff (!RST_N)
      REG_WR && REG_ADDR == ADDR_CAUSE && REG_WDATA[BIT_POR] && cause_q[BIT_POR]
      |=> cause_q[BIT_POR];
  endproperty
  a_keep_one: assert property (p_keep_one) else $error("power-on flag lost");
  // Port reset follows every source and the raw pin without waiting for the sequencer
  property p_port_src;
    @(posedge REF_CLK) disable iff (!RST_N) any_src || !RESET_PIN_N |-> PORT_RESET;
  endproperty
  a_port_src: assert property (p_port_src) else $error("ports not held in reset");
  property p_por_hold;
    @(posedge REF_CLK) disable iff (!RST_N) por_act |=> state_q == RSS_ST_HOLD;
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("power-on did not hold");
  // Release of every source starts a fresh count
  property p_delay_start;
    @(posedge REF_CLK) disable iff (!RST_N)
      state_q == RSS_ST_HOLD && !any_src |=> state_q == RSS_ST_DELAY && cnt_q == '0;
  endproperty
  a_delay_start: assert property (p_delay_start) else $error("delay not started");
  property p_cnt_step;
    @(posedge REF_CLK) disable iff (!RST_N)
      state_q == RSS_ST_DELAY && !any_src && state_d == RSS_ST_DELAY
      |=> cnt_q == $past(cnt_q) + TOUT_W'(1);
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("delay counter stalled");
  // Release only after the full selected time-out
  property p_run_full;
    @(posedge REF_CLK) disable iff (!RST_N)
      state_q == RSS_ST_DELAY && state_d == RSS_ST_RUN |-> cnt_q >= tout_sel - TOUT_W'(1);
  endproperty
  a_run_full: assert property (p_run_full) else $error("time-out cut short");
  property p_fetch;
    @(posedge REF_CLK) disable iff (!RST_N) $fell(CORE_RESET) |-> FETCH_VECTOR;
  endproperty
  a_fetch: assert property (p_fetch) else $error("no vector fetch");
  property p_fetch_one;
    @(posedge REF_CLK) disable iff (!RST_N) FETCH_VECTOR |=> !FETCH_VECTOR;
  endproperty
  a_fetch_one: assert property (p_fetch_one) else $error("fetch pulse too long");
  // A disabled detector must never count as a source
  property p_bod_off;
    @(posedge REF_CLK) disable iff (!RST_N) !bod_en |-> !bod_act;
  endproperty
  a_bod_off: assert property (p_bod_off) else $error("disabled brown-out acted");
  // The falling edge of the watchdog pulse starts the delay
  property p_wdt_fall;
    @(posedge REF_CLK) disable iff (!RST_N)
      $fell(wdt_pulse_q) && !any_src |=> state_q == RSS_ST_DELAY;
  endproperty
  a_wdt_fall: assert property (p_wdt_fall) else $error("watchdog fall missed");
  property p_wdt_clear;
    @(posedge REF_CLK) disable iff (!RST_N)
      REG_WR && REG_ADDR == ADDR_CAUSE && !REG_WDATA[BIT_WDT] && !wdt_pulse_q && !por_act
      |=> !cause_q[BIT_WDT];
  endproperty
  a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog flag not cleared");
  // Power-on wipes the pin and brown-out flags
  property p_por_wipe;
    @(posedge REF_CLK) disable iff (!RST_N) por_act |=> !cause_q[BIT_PIN] && !cause_q[BIT_BOD];
  endproperty
  a_por_wipe: assert property (p_por_wipe) else $error("flags survived power-on");
  c_run: cover property (@(posedge REF_CLK) disable iff (!RST_N) $fell(CORE_RESET));
  c_pin: cover property (@(posedge REF_CLK) disable iff (!RST_N) pin_act);
  c_fetch: cover property (@(posedge REF_CLK) disable iff (!RST_N) FETCH_VECTOR);
  c_wdt: cover property (@(posedge REF_CLK) disable iff (!RST_N) wdt_pulse_q);
  c_bod: cover property (@(posedge REF_CLK) disable iff (!RST_N) bod_act);
endmodule

/* File: verification/rss_src_model.sv */
// Far-side model: supply monitor, reset pin driver, watchdog time-out, droop detector.
// Assumes the bench calls set() just after a rising clock edge.
module rss_src_model (
  // Source levels toward the sequencer
  output logic supply_low,
  output logic pin_n,
  output logic wdt_exp,
  output logic bod_below
);
  timeunit 1ns;
  timeprecision 1ns;
  // All sources idle at power-up, so every event comes from the bench
  initial begin
    supply_low = 1'b0;
    pin_n = 1'b1;
    wdt_exp = 1'b0;
    bod_below = 1'b0;
  end
  // Raises or releases one of the four sources; the pin is active low
  task automatic set(input int src, input logic on);
    case (src)
      0: supply_low <= on;
      1: pin_n <= ~on;
      2: wdt_exp <= on;
      default: bod_below <= on;
    endcase
  endtask
endmodule

/* File: verification/rss_top_tb.sv */
// Bench for the reset source sequencer: source events, random fuses, cause and irq registers.
// Assumes 100 MHz and start-up time-outs shortened to 8, 12, 16 and 20 cycles.
module rss_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic supply_low, pin_n, wdt_exp, bod_below;
  logic wdt_en = 1'b1;
  logic wdt_int = 1'b0;
  logic [2:0] bod_fuse = 3'h5;
  logic [1:0] startup_time_fuses = 2'h0;
  logic [3:0] cks = 4'h0;
  logic port_rst, core_rst, fetch, wdt_pulse, irq;
  logic [1:0] trip;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [7:0] rdata;
  logic [7:0] want_cause = 8'h00;
  int miscompares = 0;
  int checks = 0;
  int seed = 32'ha33b;
  int n;
  int cycles = 0;

  rss_top #(.TOUT_CYC0(20'h00008), .TOUT_CYC1(20'h0000c), .TOUT_CYC2(20'h00010),
    .TOUT_CYC3(20'h00014)) u_rss_top (.REF_CLK(ref_clk), .RST_N(rst_n),
    .SUPPLY_LOW(supply_low), .RESET_PIN_N(pin_n), .WDT_EXPIRE(wdt_exp),
    .WDT_ENABLE(wdt_en), .WDT_INT_ENABLE(wdt_int), .BOD_BELOW(bod_below),
    .BROWNOUT_LEVEL_FUSES(bod_fuse), .STARTUP_TIME_FUSES(startup_time_fuses), .CLOCK_SELECT_FUSES(cks),
    .PORT_RESET(port_rst), .CORE_RESET(core_rst), .FETCH_VECTOR(fetch),
    .WDT_RESET_PULSE(wdt_pulse), .BOD_TRIP_SEL(trip), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr_s), .REG_RD(rd_s), .REG_RDATA(rdata), .IRQ(irq));
  rss_src_model u_rss_src_model (.supply_low(supply_low), .pin_n(pin_n), .wdt_exp(wdt_exp),
    .bod_below(bod_below));

  // Free-running reference clock
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  // Hang guard: the whole run needs well under two thousand cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      stop_test();
    end
  end

  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] want, input string what);
    checks++;
    if (got !== want) begin
      miscompares++;
      $display("ERROR %0t %s got %h want %h", $time, what, got, want);
    end
  endtask
  // Stretch length may exceed the time-out by at most 10 cycles of latency
  task automatic chk_rng(input int got, input int lo, input string what);
    checks++;
    if (got < lo || got > lo + 10) begin
      miscompares++;
      $display("ERROR %0t %s stretch %0d cycles, floor %0d", $time, what, got, lo);
    end
  endtask
  // Bus cycles; an idle cycle after each keeps strobes from being reassigned at once
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    addr <= a;
    wdata <= v;
    wr_s <= 1'b1;
    cyc(1);
    wr_s <= 1'b0;
    cyc(1);
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] want, input string what);
    addr <= a;
    rd_s <= 1'b1;
    cyc(1);
    rd_s <= 1'b0;
    chk(rdata, want, what);
    cyc(1);
  endtask
  function automatic logic [7:0] exp_trip(input int f);
    return (f == 6) ? 8'h01 : (f == 5) ? 8'h02 : (f == 4) ? 8'h03 : 8'h00;
  endfunction
  // Fires one source, follows the stretched reset back to run, checks the cause
  task automatic hit(input int src, input int len, input logic [7:0] flag, input string what);
    int p;
    logic up;
    p = 0;
    startup_time_fuses <= 2'($random(seed));
    cks <= 4'($random(seed));
    u_rss_src_model.set(src, 1'b1);
    #1;
    if (src < 2) chk({7'h0, port_rst}, 8'h01, "port reset");
    cyc(len);
    u_rss_src_model.set(src, 1'b0);
    n = 0;
    up = core_rst;
    while (!(up === 1'b1 && core_rst === 1'b0) && n < 2000) begin
      if (wdt_pulse === 1'b1) p++;
      cyc(1);
      n++;
      up = up | core_rst;
    end
    chk_rng(n, 8 + 4 * int'(startup_time_fuses ^ cks[1:0]), what);
    chk(8'(p), (src == 2) ? 8'h01 : 8'h00, "watchdog pulse");
    // Fetch pulse rises on the same edge that ends the core reset
    chk({7'h0, fetch}, 8'h01, "vector fetch");
    cyc(1);
    want_cause = (src == 0) ? flag : (want_cause | flag);
    rchk(rss_pkg::ADDR_CAUSE, want_cause, what);
    $display("test %s done", what);
  endtask
  // An event that must not reset the core
  task automatic miss(input int src, input int len, input string what);
    u_rss_src_model.set(src, 1'b1);
    cyc(len);
    u_rss_src_model.set(src, 1'b0);
    cyc(6);
    chk({7'h0, core_rst}, 8'h00, what);
    rchk(rss_pkg::ADDR_CAUSE, want_cause, what);
    $display("test %s done", what);
  endtask
  task automatic stop_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    cyc(5);
    rst_n <= 1'b1;
    cyc(60);
    rchk(rss_pkg::ADDR_CAUSE, 8'h01, "power-up cause");
    wr(rss_pkg::ADDR_CAUSE, 8'h00);
    wr(rss_pkg::ADDR_STAT, 8'hff);
    rchk(rss_pkg::ADDR_CAUSE, 8'h00, "cleared cause");
    hit(1, 260, 8'h02, "pin");
    hit(2, 1, 8'h08, "watchdog");
    hit(3, 3, 8'h04, "brown-out");
    miss(1, 100, "short pin");
    wdt_int <= 1'b1;
    miss(2, 1, "watchdog irq mode");
    wdt_int <= 1'b0;
    wdt_en <= 1'b0;
    miss(2, 1, "watchdog off");
    wdt_en <= 1'b1;
    bod_fuse <= 3'h7;
    miss(3, 3, "brown-out off");
    for (int f = 0; f < 8; f++) begin
      bod_fuse <= 3'(f);
      cyc(1);
      chk({6'h0, trip}, exp_trip(f), "trip level");
    end
    bod_fuse <= 3'h5;
    rchk(rss_pkg::ADDR_STAT, 8'h0e, "status");
    chk({7'h0, irq}, 8'h00, "irq masked");
    wr(rss_pkg::ADDR_MASK, 8'h04);
    rchk(rss_pkg::ADDR_MASK, 8'h04, "mask");
    chk({7'h0, irq}, 8'h01, "irq raised");
    wr(rss_pkg::ADDR_STAT, 8'h04);
    chk({7'h0, irq}, 8'h00, "irq cleared");
    rchk(rss_pkg::ADDR_STAT, 8'h0a, "status w1c");
    rchk(4'hf, 8'h00, "unmapped");
    wr(rss_pkg::ADDR_CAUSE, {4'($random(seed)), 4'hf});
    rchk(rss_pkg::ADDR_CAUSE, want_cause, "write ones");
    hit(0, 5, 8'h01, "power-on");
    wr(rss_pkg::ADDR_CAUSE, 8'hf0);
    rchk(rss_pkg::ADDR_CAUSE, 8'h00, "write zeros");
    $display("test registers done");
    stop_test();
  end
endmodule
